/* nvrc_regs.svh */
// Purpose: register offsets, bit positions, keys and timing counts
// Assumes: 200 MHz mclk, 8-bit register port
// Notes: definitions only
`ifndef NVRC_REGS_SVH
`define NVRC_REGS_SVH

// Register offsets
`define NV_REG_CTRL 3'h0
`define NV_REG_KEY 3'h1
`define NV_REG_ADRL 3'h2
`define NV_REG_ADRH 3'h3
`define NV_REG_DATL 3'h4
`define NV_REG_DATH 3'h5

// Bits of memop_control
`define NV_B_RD 0
`define NV_B_WR 1
`define NV_B_PERMIT 2
`define NV_B_ERASE 3
`define NV_B_LATCH 4
`define NV_B_DONE 5
`define NV_B_SPACE 6
`define NV_B_IRQEN 7

// Keys and values
`define NV_KEY1 8'h55
`define NV_KEY2 8'hAA
`define NV_ERASED 14'h3FFF
`define NV_FLASH_END 15'h2000
`define NV_UID_LAST 15'h0003
`define NV_WRT_LO_END 15'h0200
`define NV_WRT_HI_END 15'h1000
`define NV_EE_HI 7'h70
`define NV_IND_EE 8'h70
`define NV_IND_FLASH_BIT 15
`define NV_LOCK_NONE 2'h3
`define NV_LOCK_LO 2'h2
`define NV_LOCK_HI 2'h1

// Timed operations
`define NV_CLK_NS 5
`define NV_ERASE_NS 20000
`define NV_WRITE_NS 15000
`define NV_EE_NS 10000
`define NV_ERASE_CYC ((`NV_ERASE_NS + `NV_CLK_NS - 1) / `NV_CLK_NS)
`define NV_WRITE_CYC ((`NV_WRITE_NS + `NV_CLK_NS - 1) / `NV_CLK_NS)
`define NV_EE_CYC ((`NV_EE_NS + `NV_CLK_NS - 1) / `NV_CLK_NS)

`endif

/* nvrc_pkg.sv */
// Purpose: types of the nonvolatile memory controller
// Assumes: nvrc_regs.svh holds the numbers
// Notes: none
package nvrc_pkg;
	typedef enum logic [1:0] {M_IDLE = 2'b00, M_READ = 2'b01, M_BUSY = 2'b11} nvrc_mode_t;
	typedef enum logic [1:0] {U_IDLE = 2'b00, U_K1 = 2'b01, U_K2 = 2'b11} nvrc_unlock_t;
	typedef enum logic [1:0] {OP_NONE = 2'b00, OP_ERASE = 2'b01, OP_ROW = 2'b10, OP_EE = 2'b11} nvrc_op_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} nvrc_bus_t;
	typedef struct packed {
		logic en;
		logic space;
		logic [14:0] addr;
	} nvrc_arr_rd_t;
	typedef struct packed {
		nvrc_op_t op;
		logic space;
		logic [14:0] addr;
		logic [7:0] ee_data;
		logic [31:0][13:0] row;
	} nvrc_arr_wr_t;
	typedef struct packed {
		logic flash_code_lock;
		logic eeprom_code_lock;
		logic [1:0] self_program_lock;
	} nvrc_cfg_t;
	typedef struct packed {
		nvrc_mode_t mode;
		nvrc_unlock_t unlock;
		logic rd_go;
		logic prog_go;
		logic modify_permit;
		logic erase_sel;
		logic latch_only;
		logic config_space_select;
		logic memop_done_flag;
		logic memop_done_irq_enable;
		logic [14:0] addr;
		logic [13:0] data;
		logic [31:0][13:0] latch;
		logic [11:0] timer;
		logic rd_src;
		nvrc_arr_rd_t arr_rd;
		nvrc_arr_wr_t arr_wr;
		logic pump_en;
		logic stall;
		logic [13:0] ind_data;
		logic [7:0] rdata;
		logic irq;
		nvrc_cfg_t sync1;
		nvrc_cfg_t sync2;
		logic ext_flash_permit;
		logic ext_eeprom_permit;
	} nvrc_state_t;
endpackage

/* nvrc_ctrl.sv */
// Purpose: nonvolatile memory read, unlock and write control
// Assumes: one clock, arrays read combinationally when arr_rd.en
// Notes: arrays and pump act on arr_wr.op while pump_en is high
//
// How it works
// RULE1 - flash erases to ones, programs zeros
// RULE2 - flash holds 8192 words of 14 bits
// RULE3 - row is 32 words, smallest erase
// RULE4 - hidden row latches loaded through data pair
// RULE5 - code locks block only external programmer; here they also refuse register reads
// RULE6 - self program lock protects flash regions
// RULE7 - no bulk erase from software
// RULE8 - EEPROM 256 bytes, each written alone
// RULE9 - indirect read stalls one cycle, one word
// RULE10 - indirect stores never touch memory
// RULE11 - ID words writable, config words read only
// RULE12 - code protected refuses register interface reads
// RULE13 - software selects space, then loads address
// RULE14 - read go stalls, data next cycle
// RULE15 - hardware clears read go when done
// RULE16 - data pair holds until read or write
// RULE17 - unlock needed before any modifying operation
// RULE18 - keys 55h then AAh then go
// RULE19 - flash operations stall until complete
// RULE20 - no padding needed after go
// RULE21 - software masks interrupts around unlock
// RULE22 - internal timer and pump time operations
// RULE23 - EEPROM done clears go, flags, interrupts
// RULE24 - EEPROM write ignores go clear, completes
// RULE25 - protected erase clears go, does nothing
// RULE26 - any other access resets unlock tracker
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`include "nvrc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module nvrc_ctrl (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Register port
	input wire nvrc_pkg::nvrc_bus_t bus,
	output var logic [7:0] rdata,
	// Indirect access from the CPU
	input wire logic ind_rd,
	input wire logic ind_wr,
	input wire logic [15:0] ind_addr,
	output var logic [13:0] ind_data,
	output var logic cpu_stall,
	// Configuration fuses
	input wire nvrc_pkg::nvrc_cfg_t cfg,
	output var logic ext_flash_permit,
	output var logic ext_eeprom_permit,
	// Storage arrays and pump
	output var nvrc_pkg::nvrc_arr_rd_t arr_rd,
	input wire logic [13:0] arr_rdata,
	output var nvrc_pkg::nvrc_arr_wr_t arr_wr,
	output var logic pump_en,
	output var logic memop_done_irq
);
	import nvrc_pkg::*;

	nvrc_state_t s;
	nvrc_state_t next_s;
	logic [31:0][13:0] row_merge;
	logic [13:0] new_word;
	logic tgt_flash;
	logic tgt_uid;
	logic tgt_ee;
	logic tgt_cfg_ro;
	logic wr_protect;
	logic rd_refused;
	logic ind_ee;
	logic ind_flash;

	// ************************************************************
	// Target decode
	// ************************************************************
	assign new_word = s.data;
	assign tgt_flash = !s.config_space_select && (s.addr < `NV_FLASH_END); // see RULE2
	assign tgt_uid = s.config_space_select && (s.addr <= `NV_UID_LAST);
	assign tgt_ee = s.config_space_select && (s.addr[14:8] == `NV_EE_HI); // see RULE8
	assign tgt_cfg_ro = s.config_space_select && !tgt_uid && !tgt_ee; // see RULE11
	assign ind_ee = (ind_addr[15:8] == `NV_IND_EE);
	assign ind_flash = ind_addr[`NV_IND_FLASH_BIT];

	// Self program lock regions
	always_comb begin
		case (s.sync2.self_program_lock)
			`NV_LOCK_NONE: wr_protect = 1'b0;
			`NV_LOCK_LO: wr_protect = tgt_flash && (s.addr < `NV_WRT_LO_END); // see RULE6
			`NV_LOCK_HI: wr_protect = tgt_flash && (s.addr < `NV_WRT_HI_END); // see RULE6
			default: wr_protect = tgt_flash; // see RULE6
		endcase
	end

	// Register interface reads blocked under code protection
	assign rd_refused = tgt_ee ? s.sync2.eeprom_code_lock : s.sync2.flash_code_lock; // see RULE12

	// ************************************************************
	// Row latches merged with the data pair
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_row
			assign row_merge[gi] = (s.addr[4:0] == 5'(gi)) ? new_word : s.latch[gi]; // see RULE3, RULE4
		end
	endgenerate

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic rd_started;
		rd_started = 1'b0;
		next_s = s;
		next_s.rdata = 8'h00;
		next_s.stall = 1'b0;
		next_s.arr_rd.en = 1'b0;
		next_s.sync1 = cfg;
		next_s.sync2 = s.sync1;
		next_s.ext_flash_permit = !s.sync2.flash_code_lock; // see RULE5
		next_s.ext_eeprom_permit = !s.sync2.eeprom_code_lock; // see RULE5

		// Finish a read or a timed operation
		case (s.mode)
			M_READ: begin
				if (s.rd_src) begin
					next_s.ind_data = arr_rdata; // see RULE9
				end else begin
					next_s.data = arr_rdata; // see RULE14, RULE16
				end
				next_s.rd_go = 1'b0; // see RULE15
				next_s.mode = M_IDLE;
			end
			M_BUSY: begin
				if (s.timer == 12'h000) begin
					next_s.prog_go = 1'b0; // see RULE23
					next_s.memop_done_flag = 1'b1; // see RULE23
					next_s.arr_wr.op = OP_NONE;
					next_s.pump_en = 1'b0;
					next_s.mode = M_IDLE;
				end else begin
					next_s.timer = s.timer - 12'h001; // see RULE22
					next_s.stall = (s.arr_wr.op != OP_EE); // see RULE19
				end
			end
			default: begin
				next_s.mode = M_IDLE;
			end
		endcase

		// Any access other than the next step drops the unlock
		if (bus.wr || bus.rd) begin
			next_s.unlock = U_IDLE; // see RULE26
		end

		// Register reads
		if (bus.rd) begin
			case (bus.addr)
				`NV_REG_CTRL: begin
					next_s.rdata[`NV_B_RD] = s.rd_go;
					next_s.rdata[`NV_B_WR] = s.prog_go;
					next_s.rdata[`NV_B_PERMIT] = s.modify_permit;
					next_s.rdata[`NV_B_ERASE] = s.erase_sel;
					next_s.rdata[`NV_B_LATCH] = s.latch_only;
					next_s.rdata[`NV_B_DONE] = s.memop_done_flag;
					next_s.rdata[`NV_B_SPACE] = s.config_space_select;
					next_s.rdata[`NV_B_IRQEN] = s.memop_done_irq_enable;
				end
				`NV_REG_ADRL: next_s.rdata = s.addr[7:0];
				`NV_REG_ADRH: next_s.rdata = {1'b0, s.addr[14:8]};
				`NV_REG_DATL: next_s.rdata = s.data[7:0];
				`NV_REG_DATH: next_s.rdata = {2'b00, s.data[13:8]};
				default: next_s.rdata = 8'h00;
			endcase
		end

		// Register writes
		if (bus.wr) begin
			case (bus.addr)
				`NV_REG_KEY: begin
					if (s.unlock == U_IDLE && bus.wdata == `NV_KEY1) begin
						next_s.unlock = U_K1; // see RULE18
					end else if (s.unlock == U_K1 && bus.wdata == `NV_KEY2) begin
						next_s.unlock = U_K2; // see RULE18
					end
				end
				`NV_REG_ADRL: next_s.addr[7:0] = bus.wdata;
				`NV_REG_ADRH: next_s.addr[14:8] = bus.wdata[6:0];
				`NV_REG_DATL: next_s.data[7:0] = bus.wdata; // see RULE16
				`NV_REG_DATH: next_s.data[13:8] = bus.wdata[5:0]; // see RULE16
				`NV_REG_CTRL: begin
					next_s.modify_permit = bus.wdata[`NV_B_PERMIT];
					next_s.erase_sel = bus.wdata[`NV_B_ERASE];
					next_s.latch_only = bus.wdata[`NV_B_LATCH];
					next_s.config_space_select = bus.wdata[`NV_B_SPACE];
					next_s.memop_done_irq_enable = bus.wdata[`NV_B_IRQEN];
					if (!bus.wdata[`NV_B_DONE] && !next_s.memop_done_flag) begin
						next_s.memop_done_flag = 1'b0;
					end else if (!bus.wdata[`NV_B_DONE] && s.mode != M_BUSY) begin
						next_s.memop_done_flag = 1'b0;
					end else if (!bus.wdata[`NV_B_DONE] && s.timer != 12'h000) begin
						next_s.memop_done_flag = 1'b0;
					end
					// Read request through the register pair
					if (bus.wdata[`NV_B_RD] && s.mode == M_IDLE && !rd_refused) begin
						next_s.rd_go = 1'b1;
						next_s.mode = M_READ;
						next_s.stall = 1'b1; // see RULE14
						next_s.rd_src = 1'b0;
						next_s.arr_rd.en = 1'b1;
						next_s.arr_rd.space = s.config_space_select; // see RULE13
						next_s.arr_rd.addr = s.addr;
						rd_started = 1'b1;
					end
					// Program go only after both keys, else dropped
					if (bus.wdata[`NV_B_WR] && s.unlock == U_K2 && s.mode == M_IDLE
						&& bus.wdata[`NV_B_PERMIT]) begin // see RULE17, RULE18
						next_s.arr_wr.space = s.config_space_select;
						next_s.arr_wr.addr = s.addr;
						if ((tgt_flash || tgt_uid) && bus.wdata[`NV_B_LATCH]) begin
							next_s.latch = row_merge; // see RULE4
						end else if ((tgt_flash || tgt_uid) && !wr_protect) begin
							next_s.prog_go = 1'b1;
							next_s.mode = M_BUSY;
							next_s.pump_en = 1'b1; // see RULE22
							next_s.stall = 1'b1; // see RULE19, RULE20
							if (bus.wdata[`NV_B_ERASE]) begin
								next_s.arr_wr.op = OP_ERASE; // see RULE3, RULE7
								next_s.timer = 12'(`NV_ERASE_CYC);
							end else begin
								next_s.arr_wr.op = OP_ROW; // see RULE7
								next_s.arr_wr.row = row_merge;
								next_s.latch = {32{`NV_ERASED}}; // see RULE1
								next_s.timer = 12'(`NV_WRITE_CYC);
							end
						end else if (tgt_ee) begin
							next_s.prog_go = 1'b1;
							next_s.mode = M_BUSY;
							next_s.pump_en = 1'b1; // see RULE22
							next_s.arr_wr.op = OP_EE; // see RULE8
							next_s.arr_wr.ee_data = s.data[7:0];
							next_s.timer = 12'(`NV_EE_CYC);
						end
						// Protected or read-only targets leave go clear
						if (wr_protect || tgt_cfg_ro) begin
							next_s.prog_go = 1'b0; // see RULE6, RULE11, RULE25
						end
					end
					// Go cannot be cleared by software mid-operation
					if (s.mode == M_BUSY && s.timer != 12'h000) begin
						next_s.prog_go = 1'b1; // see RULE24
					end
				end
				default: begin
					next_s.unlock = U_IDLE;
				end
			endcase
		end

		// Indirect read; stores are ignored entirely
		if (ind_rd && !ind_wr && !rd_started && s.mode == M_IDLE && (ind_ee || ind_flash)) begin // see RULE10
			next_s.mode = M_READ;
			next_s.stall = 1'b1; // see RULE9
			next_s.rd_src = 1'b1;
			next_s.arr_rd.en = 1'b1;
			next_s.arr_rd.space = ind_ee;
			next_s.arr_rd.addr = ind_ee ? {`NV_EE_HI, ind_addr[7:0]} : {2'b00, ind_addr[12:0]}; // see RULE2
		end

		next_s.irq = next_s.memop_done_flag && next_s.memop_done_irq_enable; // see RULE23
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.latch <= {32{`NV_ERASED}}; // see RULE1
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign rdata = s.rdata;
	assign ind_data = s.ind_data;
	assign cpu_stall = s.stall;
	assign ext_flash_permit = s.ext_flash_permit;
	assign ext_eeprom_permit = s.ext_eeprom_permit;
	assign arr_rd = s.arr_rd;
	assign arr_wr = s.arr_wr;
	assign pump_en = s.pump_en;
	assign memop_done_irq = s.irq;
endmodule

`default_nettype wire

/* nvrc_array_model.sv */
// Purpose: storage array stand-in for nvrc_ctrl
// Assumes: arrays answer reads in the same cycle
// Notes: read word is derived from space and address
`timescale 1ns/100ps
`default_nettype none
module nvrc_array_model (
	// Array read side
	input wire nvrc_pkg::nvrc_arr_rd_t arr_rd,
	output logic [13:0] arr_rdata
);
	import nvrc_pkg::*;
	logic [13:0] word;
	// One 14-bit word per read
	assign word = {arr_rd.space, arr_rd.addr[12:0]};
	// Unselected array shows the inverse pattern
	assign arr_rdata = arr_rd.en ? word : ~word;
endmodule
`default_nettype wire

/* nvrc_ctrl_assertions.sv */
// Purpose: port checks of nvrc_ctrl
// Assumes: register layout of nvrc_regs.svh
// Notes: bound to every nvrc_ctrl
`include "nvrc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module nvrc_ctrl_assertions (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Watched ports
	input wire nvrc_pkg::nvrc_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic ind_rd,
	input wire logic ind_wr,
	input wire logic [15:0] ind_addr,
	input wire logic [13:0] ind_data,
	input wire logic cpu_stall,
	input wire nvrc_pkg::nvrc_cfg_t cfg,
	input wire logic ext_flash_permit,
	input wire logic ext_eeprom_permit,
	input wire nvrc_pkg::nvrc_arr_rd_t arr_rd,
	input wire logic [13:0] arr_rdata,
	input wire nvrc_pkg::nvrc_arr_wr_t arr_wr,
	input wire logic pump_en
);
	import nvrc_pkg::*;
	logic [11:0] run;
	logic quiet;
	assign quiet = !cpu_stall && !pump_en;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			run <= 12'h000;
		end else begin
			run <= pump_en ? run + 12'h001 : 12'h000;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	pump_op_a: assert property (pump_en == (arr_wr.op != OP_NONE))
		else $error("pump and op disagree");
	pump_cause_a: assert property (!bus.wr && !pump_en |=> !pump_en)
		else $error("op without register write");
	key_order_a: assert property (bus.wr && !($past(bus.wr) && $past(bus.addr) == `NV_REG_KEY
		&& $past(bus.wdata) == `NV_KEY2) && !pump_en |=> !pump_en)
		else $error("op without keys");
	flash_stall_a: assert property (pump_en && arr_wr.op != OP_EE |-> cpu_stall)
		else $error("flash op without stall");
	op_length_a: assert property ($fell(pump_en) |-> run > 12'h7CF)
		else $error("op ended early");
	rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data outside slot");
	ind_read_a: assert property (ind_rd && !ind_wr && ind_addr[15] && quiet && !bus.wr |=> cpu_stall && arr_rd.en
		##1 !cpu_stall && ind_data == $past(arr_rdata))
		else $error("indirect read timing");
	reg_read_a: assert property (bus.wr && bus.addr == `NV_REG_CTRL && bus.wdata[1:0] == 2'h1 && quiet
		&& !ind_rd && ext_flash_permit && ext_eeprom_permit |=> cpu_stall ##1 !cpu_stall)
		else $error("register read timing");
	lock_read_a: assert property (bus.wr && bus.addr == `NV_REG_CTRL && bus.wdata[1:0] == 2'h1 && quiet
		&& !ind_rd && !ext_flash_permit && !ext_eeprom_permit |=> !cpu_stall)
		else $error("locked read ran");
	permit_a: assert property ($past(arst_n, 4) && $stable(cfg)[*4] |-> ext_flash_permit
		== !cfg.flash_code_lock && ext_eeprom_permit == !cfg.eeprom_code_lock)
		else $error("permit mismatch");
endmodule
bind nvrc_ctrl nvrc_ctrl_assertions i_chk (.mclk(mclk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
	.ind_rd(ind_rd), .ind_wr(ind_wr), .ind_addr(ind_addr), .ind_data(ind_data), .cpu_stall(cpu_stall), .cfg(cfg),
	.ext_flash_permit(ext_flash_permit), .ext_eeprom_permit(ext_eeprom_permit), .arr_rd(arr_rd),
	.arr_rdata(arr_rdata), .arr_wr(arr_wr), .pump_en(pump_en));
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench of nvrc_ctrl
// Assumes: array model answers reads at once
// Notes: full-length op timers, about 9k cycles
`include "nvrc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import nvrc_pkg::*;
	logic mclk, arst_n, ind_rd, ind_wr, pump_en, cpu_stall, irq, flash_ok, ee_ok;
	logic [7:0] rdata, v;
	logic [15:0] ind_addr;
	logic [13:0] ind_data, arr_rdata;
	nvrc_bus_t bus;
	nvrc_cfg_t cfg;
	nvrc_arr_rd_t arr_rd;
	nvrc_arr_wr_t arr_wr;
	int fails, compares;
	nvrc_ctrl i_dut (.mclk(mclk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .ind_rd(ind_rd),
		.ind_wr(ind_wr), .ind_addr(ind_addr), .ind_data(ind_data), .cpu_stall(cpu_stall), .cfg(cfg),
		.ext_flash_permit(flash_ok), .ext_eeprom_permit(ee_ok), .arr_rd(arr_rd), .arr_rdata(arr_rdata),
		.arr_wr(arr_wr), .pump_en(pump_en), .memop_done_irq(irq));
	nvrc_array_model i_arr (.arr_rd(arr_rd), .arr_rdata(arr_rdata));
	// ****************
	// Bus tasks
	// ****************
	task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
	endtask
	task automatic idl;
		bus <= '0;
		@(posedge mclk);
		#1;
	endtask
	task automatic rd(input logic [2:0] a);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		bus <= '0;
		#1;
		v = rdata;
	endtask
	task automatic unlk(input logic [7:0] c);
		// Three steps back to back, nothing may break in
		wr(`NV_REG_KEY, `NV_KEY1);
		wr(`NV_REG_KEY, `NV_KEY2);
		wr(`NV_REG_CTRL, c);
		idl;
	endtask
	task automatic at(input logic [7:0] c, input logic [15:0] a);
		wr(`NV_REG_CTRL, c);
		wr(`NV_REG_ADRL, a[7:0]);
		wr(`NV_REG_ADRH, a[15:8]);
	endtask
	task automatic wt(input int n);
		for (int i = 0; i < n && pump_en; i++) begin
			@(posedge mclk);
			#1;
		end
		if (pump_en !== 1'b0) begin
			fails++;
			print_verdict;
		end
	endtask
	task automatic setcfg(input logic [3:0] c);
		cfg <= c;
		repeat (6) idl;
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_read;
		logic [15:0] a [2] = '{16'h0123, 16'h0002};
		for (int s = 0; s < 2; s++) begin
			at(s ? 8'h40 : 8'h00, a[s]);
			wr(`NV_REG_CTRL, s ? 8'h41 : 8'h01);
			idl;
			rd(`NV_REG_DATL);
			chk("data low", v, a[s][7:0]);
			rd(`NV_REG_DATH);
			chk("data high", v, {2'b00, s[0], a[s][12:8]});
			rd(`NV_REG_CTRL);
			chk("read go", v[0], 1'b0);
		end
		repeat (3) idl;
		rd(`NV_REG_DATH);
		chk("data held", v, 8'h20);
		$display("read test done");
	endtask
	task automatic t_lock;
		setcfg(4'hF);
		chk("ext flash locked", flash_ok, 1'b0);
		chk("ext eeprom locked", ee_ok, 1'b0);
		wr(`NV_REG_DATL, 8'h11);
		wr(`NV_REG_DATH, 8'h22);
		wr(`NV_REG_CTRL, 8'h01);
		idl;
		rd(`NV_REG_CTRL);
		chk("locked go", v[0], 1'b0);
		rd(`NV_REG_DATL);
		chk("kept low", v, 8'h11);
		rd(`NV_REG_DATH);
		chk("kept high", v, 8'h22);
		setcfg(4'h3);
		chk("ext flash open", flash_ok, 1'b1);
		chk("ext eeprom open", ee_ok, 1'b1);
		$display("lock test done");
	endtask
	task automatic t_ee;
		at(8'h44, 16'h7005);
		wr(`NV_REG_DATL, 8'h5A);
		unlk(8'h46);
		chk("ee op", arr_wr.op, OP_EE);
		chk("ee data", arr_wr.ee_data, 8'h5A);
		chk("ee no stall", cpu_stall, 1'b0);
		wr(`NV_REG_CTRL, 8'h44);
		idl;
		chk("go clear ignored", pump_en, 1'b1);
		wt(3000);
		rd(`NV_REG_CTRL);
		chk("ee done", v, 8'h64);
		wr(`NV_REG_CTRL, 8'hE0);
		idl;
		idl;
		chk("irq on", irq, 1'b1);
		wr(`NV_REG_CTRL, 8'h80);
		idl;
		idl;
		chk("irq off", irq, 1'b0);
		$display("eeprom test done");
	endtask
	task automatic t_bad;
		logic [7:0] k [3][2] = '{'{8'h55, 8'hAB}, '{8'hAA, 8'h55}, '{8'h55, 8'hAA}};
		at(8'h44, 16'h7006);
		for (int i = 0; i < 3; i++) begin
			wr(`NV_REG_KEY, k[i][0]);
			if (i == 2) begin
				rd(`NV_REG_DATL);
			end
			wr(`NV_REG_KEY, k[i][1]);
			wr(`NV_REG_CTRL, 8'h46);
			idl;
			chk("bad unlock", pump_en, 1'b0);
		end
		at(8'h44, 16'h0005);
		unlk(8'h46);
		chk("config write", pump_en, 1'b0);
		$display("unlock test done");
	endtask
	task automatic t_flash;
		setcfg(4'h0);
		at(8'h0C, 16'h0040);
		unlk(8'h0E);
		chk("protected erase", pump_en, 1'b0);
		rd(`NV_REG_CTRL);
		chk("protected go", v[1], 1'b0);
		setcfg(4'h3);
		unlk(8'h0E);
		chk("erase op", arr_wr.op, OP_ERASE);
		chk("erase stall", cpu_stall, 1'b1);
		wt(5000);
		wr(`NV_REG_DATL, 8'h34);
		wr(`NV_REG_DATH, 8'h12);
		at(8'h14, 16'h0045);
		unlk(8'h16);
		chk("latch only", pump_en, 1'b0);
		at(8'h04, 16'h0046);
		wr(`NV_REG_DATL, 8'hBC);
		wr(`NV_REG_DATH, 8'h0A);
		unlk(8'h06);
		chk("row op", arr_wr.op, OP_ROW);
		chk("row latch", arr_wr.row[5], 14'h1234);
		chk("row merge", arr_wr.row[6], 14'h0ABC);
		chk("row blank", arr_wr.row[0], 14'h3FFF);
		wt(4000);
		$display("flash test done");
	endtask
	task automatic t_ind;
		ind_addr <= 16'h8123;
		ind_rd <= 1'b1;
		ind_wr <= 1'b0;
		@(posedge mclk);
		ind_rd <= 1'b0;
		ind_wr <= 1'b1;
		#1;
		chk("ind stall", cpu_stall, 1'b1);
		@(posedge mclk);
		ind_wr <= 1'b0;
		#1;
		chk("ind data", ind_data, 14'h0123);
		chk("ind resume", cpu_stall, 1'b0);
		chk("ind store", pump_en, 1'b0);
		$display("indirect test done");
	endtask
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		arst_n = 1'b0;
		bus = '0;
		ind_rd = 1'b0;
		ind_wr = 1'b0;
		ind_addr = 16'h0000;
		cfg = 4'h3;
		fails = 0;
		compares = 0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (6) idl;
		t_read;
		t_lock;
		t_ee;
		t_bad;
		t_flash;
		t_ind;
		print_verdict;
	end
endmodule
`default_nettype wire
